// >>> inc/clkgen_defs.vh
// Constants of the clock generation and distribution unit.
`ifndef CLKGEN_DEFS_VH
`define CLKGEN_DEFS_VH
`define NUM_BUS_CLOCKS        5
`define NUM_UNITS             6
`define UNIT_ETH              0
`define UNIT_SD_I2C1          1
`define UNIT_SEC              2
`define UNIT_USB              3
`define UNIT_PCIE             4
`define UNIT_PCI_DMA          5
`define UCM_OFF               2'h0
`define UCM_FULL              2'h1
`define UCM_HALF              2'h2
`define UCM_THIRD             2'h3
`define UNIT_CTRL_RESET       12'h7FF
`define OUT_CTRL_RESET        5'h00
`define MULT_FIRST_VALID      4'h2
`define VCO_CODE_DIV4         2'h0
`define VCO_CODE_DIV8         2'h1
`define VCO_CODE_DIV2         2'h2
`define VCO_CODE_DIV1         2'h3
`define LB_DIV_CODE_2         2'h0
`define LB_DIV_CODE_4         2'h1
`define LB_HALF_2             4'h1
`define LB_HALF_4             4'h2
`define LB_HALF_8             4'h4
`define HALF_DIV2             4'h1
`endif

// >>> tb/clkgen_checker_asserts.sv
// Port-level checker of the clock generation unit.
`timescale 1ns/1ps
module clkgen_checker (
	input wire        CLK,
	input wire        RESET_N,
	input wire        UNIT_CLOCK_WRITE,
	input wire [11:0] UNIT_CLOCK_WRITE_DATA,
	input wire [4:0]  BUS_CLOCK_OUTPUT_ENABLE,
	input wire [4:0]  BUS_CLOCK_OUTPUTS,
	input wire [7:0]  SYNC_TO_BUS_RATIO,
	input wire        MULT_RESERVED,
	input wire        MEMORY_CLOCK_PAIR_P,
	input wire        MEMORY_CLOCK_PAIR_N,
	input wire [11:0] UNIT_CLOCK_CONTROL,
	input wire [5:0]  UNIT_CLOCK_ENABLE,
	input wire        I2C2_CLOCK_ENABLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	unit_write_a: assert property (UNIT_CLOCK_WRITE && !UNIT_CLOCK_WRITE_DATA[11] |=>
		UNIT_CLOCK_CONTROL == $past(UNIT_CLOCK_WRITE_DATA)) else $error("unit write lost");
	pci_refuse_a: assert property (UNIT_CLOCK_WRITE && UNIT_CLOCK_WRITE_DATA[11] |=>
		UNIT_CLOCK_CONTROL[11:10] == $past(UNIT_CLOCK_CONTROL[11:10])) else $error("bad ratio taken");
	i2c2_hold_a: assert property ($past(RESET_N) |-> I2C2_CLOCK_ENABLE) else $error("i2c2 gated");
	mem_pair_a: assert property ($rose(MEMORY_CLOCK_PAIR_P) |=>
		$fell(MEMORY_CLOCK_PAIR_P) && MEMORY_CLOCK_PAIR_N) else $error("memory pair wrong");
	bus_gate_a: assert property ((BUS_CLOCK_OUTPUTS & ~$past(BUS_CLOCK_OUTPUT_ENABLE)) == 5'h00)
		else $error("disabled output runs");
	mult_res_a: assert property (MULT_RESERVED |-> SYNC_TO_BUS_RATIO == 8'h00)
		else $error("reserved ratio nonzero");
	unit_off_a: assert property (UNIT_CLOCK_CONTROL[1:0] == 2'h0 |=> !UNIT_CLOCK_ENABLE[0])
		else $error("off unit clocked");
	unit_third_a: assert property (UNIT_CLOCK_CONTROL[5:4] == 2'h3 && UNIT_CLOCK_ENABLE[2] |=>
		!UNIT_CLOCK_ENABLE[2] ##1 !UNIT_CLOCK_ENABLE[2]) else $error("third ratio wrong");
endmodule // clkgen_checker
bind system_clock_generation clkgen_checker chk_u (.CLK(CLK), .RESET_N(RESET_N),
	.UNIT_CLOCK_WRITE(UNIT_CLOCK_WRITE), .UNIT_CLOCK_WRITE_DATA(UNIT_CLOCK_WRITE_DATA),
	.BUS_CLOCK_OUTPUT_ENABLE(BUS_CLOCK_OUTPUT_ENABLE), .BUS_CLOCK_OUTPUTS(BUS_CLOCK_OUTPUTS),
	.SYNC_TO_BUS_RATIO(SYNC_TO_BUS_RATIO), .MULT_RESERVED(MULT_RESERVED),
	.MEMORY_CLOCK_PAIR_P(MEMORY_CLOCK_PAIR_P), .MEMORY_CLOCK_PAIR_N(MEMORY_CLOCK_PAIR_N),
	.UNIT_CLOCK_CONTROL(UNIT_CLOCK_CONTROL), .UNIT_CLOCK_ENABLE(UNIT_CLOCK_ENABLE),
	.I2C2_CLOCK_ENABLE(I2C2_CLOCK_ENABLE));

// >>> tb/ref_clock_source.sv
// Reference clock sources for the host and agent clock inputs.
`timescale 1ns/1ps
module ref_clock_source #(parameter HALF_NS = 100) (
	input  wire host_sel,
	output reg  host_ref,
	output reg  bus_ref
);
	initial begin
		host_ref = 1'b0;
		bus_ref = 1'b0;
	end
	// The unused input is held at ground, as a board does in agent mode.
	always #(HALF_NS) begin
		host_ref <= host_sel ? ~host_ref : 1'b0;
		bus_ref <= host_sel ? 1'b0 : ~bus_ref;
	end
endmodule // ref_clock_source

// >>> tb/system_clock_generation_tb_top.sv
// Self-checking bench for the clock generation unit.
`timescale 1ns/1ps
module system_clock_generation_tb_top;
	reg         clk = 1'b0, reset_n = 1'b0, host = 1'b1, div = 1'b0, mem_mode = 1'b0, lb_mode = 1'b0;
	reg  [3:0]  sys_mult = 4'h6;
	reg  [6:0]  core = 7'h00;
	reg  [1:0]  vco = 2'h0, lb_div = 2'h0;
	reg  [4:0]  out_en = 5'h01;
	reg         uc_wr = 1'b0;
	reg  [11:0] uc_data = 12'h000;
	wire        host_ref, pci_clk, prim, sync, sync_loop, mult_res, mem_p, mem_n, i2c2;
	wire [4:0]  bus_out;
	wire [7:0]  ratio;
	wire [6:0]  core_q;
	wire [3:0]  vco_q;
	wire [1:0]  mem_r, lb_r;
	wire [2:0]  lb_out;
	wire [11:0] uc_ctl;
	wire [5:0]  uc_en;
	integer     n_fail = 0, comparisons = 0, i, k;
	integer     r[0:11];
	always #10 clk = ~clk;
	// The board routes the sync output straight back to the sync input.
	assign sync_loop = sync;
	ref_clock_source src_u (.host_sel(host), .host_ref(host_ref), .bus_ref(pci_clk));
	system_clock_generation dut_u (.CLK(clk), .RESET_N(reset_n), .HOST_MODE_STRAP(host),
		.REF_DIVIDE_STRAP(div), .HOST_REF_CLOCK_IN(host_ref), .PCI_CLOCK_IN(pci_clk),
		.SYSTEM_PLL_MULTIPLIER(sys_mult), .CORE_MULTIPLIER_FIELD(core), .PLL_VCO_DIVIDER(vco),
		.MEMORY_CLOCK_MODE(mem_mode), .LOCAL_BUS_CLOCK_MODE(lb_mode), .BUS_CLOCK_OUTPUT_ENABLE(out_en),
		.LOCAL_BUS_DIVIDE_RATIO(lb_div), .UNIT_CLOCK_WRITE(uc_wr), .UNIT_CLOCK_WRITE_DATA(uc_data),
		.PRIMARY_CLOCK_OUT(prim), .SYNC_OUT(sync), .BUS_CLOCK_OUTPUTS(bus_out), .SYNC_TO_BUS_RATIO(ratio),
		.MULT_RESERVED(mult_res), .CORE_MULTIPLIER(core_q), .VCO_DIVISION(vco_q), .MEMORY_CLOCK_RATIO(mem_r),
		.LOCAL_IF_CLOCK_RATIO(lb_r), .MEMORY_CLOCK_PAIR_P(mem_p), .MEMORY_CLOCK_PAIR_N(mem_n),
		.LOCAL_BUS_CLOCK_OUT(lb_out), .UNIT_CLOCK_CONTROL(uc_ctl), .UNIT_CLOCK_ENABLE(uc_en),
		.I2C2_CLOCK_ENABLE(i2c2));
	task chk(input [95:0] what, input [11:0] exp, input [11:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// Edge counts may differ by one with the window's phase.
	task chk_cnt(input [95:0] what, input integer exp, input integer got);
		begin
			comparisons = comparisons + 1;
			if ((got >= exp - 1 && got <= exp + 1) !== 1'b1) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %0d seen %0d", what, exp, got);
			end
		end
	endtask
	// Counts rising edges of six clocks and high cycles of the unit enables.
	task measure(input integer n);
		reg [5:0] p, v;
		begin
			for (k = 0; k < 12; k = k + 1) r[k] = 0;
			p = {prim, sync_loop, bus_out[1:0], lb_out[0], mem_p};
			repeat (n) begin
				@(posedge clk);
				#2;
				v = {prim, sync_loop, bus_out[1:0], lb_out[0], mem_p};
				for (k = 0; k < 6; k = k + 1) r[k] = r[k] + (v[k] & ~p[k]) + uc_en[k] * 1024;
				p = v;
			end
			for (k = 0; k < 6; k = k + 1) begin
				r[k + 6] = r[k] / 1024;
				r[k] = r[k] % 1024;
			end
		end
	endtask
	task uc_write(input [11:0] d);
		begin
			@(posedge clk);
			#2 uc_wr = 1'b1;
			uc_data = d;
			@(posedge clk);
			#2 uc_wr = 1'b0;
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d n_fail %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#100000 n_fail = n_fail + 1;
		finish_test;
	end
	initial begin
		for (i = 0; i < 4; i = i + 1) begin
			{host, div, mem_mode, lb_mode} = {i[1], i[0], i[0], i[1]};
			// With a 33 MHz reference the multipliers of passes 1 to 3 keep the bus clock between 133 and 400 MHz; pass 0 takes the reserved multiplier 1.
			{vco, lb_div, core, sys_mult} = {i[1:0], i[1:0], 7'h05 + i[6:0],
				(i == 3) ? 4'h6 : 4'h3 * i[3:0] + 4'h1};
			reset_n = 1'b0;
			repeat (8) @(posedge clk);
			#2 chk("unit reset", 12'h7FF, uc_ctl);
			chk("mem n reset", 12'h001, mem_n);
			reset_n = 1'b1;
			repeat (8) @(posedge clk);
			#2 chk("ratio", (sys_mult < 2) ? 0 : (1 + div) * sys_mult, ratio);
			chk("reserved", sys_mult < 2, mult_res);
			chk("mem pair", {11'h000, ~mem_p}, mem_n);
			chk("local all", {3{lb_out[0]}}, lb_out);
			chk("core", core, core_q);
			chk("vco", (16'h1284 >> (4 * vco)) & 4'hF, vco_q);
			chk("mem ratio", 1 + mem_mode, mem_r);
			chk("local ratio", 1 + lb_mode, lb_r);
			chk("i2c2", 1, i2c2);
			measure(200);
			chk_cnt("primary", 20, r[5]);
			chk_cnt("sync", host ? 20 >> div : 0, r[4]);
			chk_cnt("bus0", host ? 20 >> div : 0, r[2]);
			chk_cnt("bus1", 0, r[3]);
			chk_cnt("local", 200 >> (1 + (i > 2 ? 2 : i)), r[1]);
			chk_cnt("memory", 100, r[0]);
		end
		out_en = 5'h02;
		measure(200);
		chk_cnt("bus0 off", 0, r[2]);
		chk_cnt("bus1 on", 10, r[3]);
		uc_write(12'h5E4);
		chk("unit ctl", 12'h5E4, uc_ctl);
		measure(60);
		for (i = 0; i < 6; i = i + 1)
			chk_cnt("unit en", i == 0 ? 0 : i == 2 ? 30 : i == 3 ? 20 : 60, r[i + 6]);
		uc_write(12'hB00);
		chk("half refused", 12'h700, uc_ctl);
		uc_write(12'hC00);
		chk("refused", 12'h400, uc_ctl);
		uc_write(12'h000);
		measure(30);
		chk_cnt("pci off", 0, r[11]);
		finish_test;
	end
endmodule // system_clock_generation_tb_top

// >>> verilog/clock_divider.v
// Divider that toggles its output after a programmable number of advance ticks.
`timescale 1ns/1ps
module clock_divider (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       tick,
	input  wire [3:0] half_count,
	output reg        clk_out
);
	reg [3:0] count_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 4'h0;
			clk_out <= 1'b0;
		end else if (tick) begin
			if (count_q + 4'h1 >= half_count) begin
				count_q <= 4'h0;
				clk_out <= ~clk_out;
			end else begin
				count_q <= count_q + 4'h1;
			end
		end
	end
endmodule // clock_divider

// >>> verilog/system_clock_generation.v
// Clock selection, division, multiplier decode and unit clock gating.
`timescale 1ns/1ps
`include "clkgen_defs.vh"
//Contract
// - Host strap picks host ref, else bus clock
// - Host reference feeds divide-by-two and muxes
// - Divide strap picks sync output divided or not
// - Per-output enable gates each bus clock output
// - System PLL makes bus, memory, local clocks
// - Bus clock = sync x (1+div) x multiplier
// - Host mode: sync x (1+div) equals reference
// - Core PLL multiplies system bus clock
// - Multipliers come from reset configuration word
// - Memory clock halved into differential pair
// - Local bus clock divided by two, four, eight
// - Units reset to default ratio, software changes
// - Units default third; PCI/DMA full, off only
// - Second I2C clock is never configurable
// - Multiplier field decode, two codes reserved
// - VCO divider decode four, eight, two, one
module system_clock_generation (
	input  wire                       CLK,
	input  wire                       RESET_N,
	input  wire                       HOST_MODE_STRAP,
	input  wire                       REF_DIVIDE_STRAP,
	input  wire                       HOST_REF_CLOCK_IN,
	input  wire                       PCI_CLOCK_IN,
	input  wire [3:0]                 SYSTEM_PLL_MULTIPLIER,
	input  wire [6:0]                 CORE_MULTIPLIER_FIELD,
	input  wire [1:0]                 PLL_VCO_DIVIDER,
	input  wire                       MEMORY_CLOCK_MODE,
	input  wire                       LOCAL_BUS_CLOCK_MODE,
	input  wire [`NUM_BUS_CLOCKS-1:0] BUS_CLOCK_OUTPUT_ENABLE,
	input  wire [1:0]                 LOCAL_BUS_DIVIDE_RATIO,
	input  wire                       UNIT_CLOCK_WRITE,
	input  wire [11:0]                UNIT_CLOCK_WRITE_DATA,
	output reg                        PRIMARY_CLOCK_OUT,
	output reg                        SYNC_OUT,
	output reg  [`NUM_BUS_CLOCKS-1:0] BUS_CLOCK_OUTPUTS,
	output reg  [7:0]                 SYNC_TO_BUS_RATIO,
	output reg                        MULT_RESERVED,
	output reg  [6:0]                 CORE_MULTIPLIER,
	output reg  [3:0]                 VCO_DIVISION,
	output reg  [1:0]                 MEMORY_CLOCK_RATIO,
	output reg  [1:0]                 LOCAL_IF_CLOCK_RATIO,
	output reg                        MEMORY_CLOCK_PAIR_P,
	output reg                        MEMORY_CLOCK_PAIR_N,
	output reg  [2:0]                 LOCAL_BUS_CLOCK_OUT,
	output reg  [11:0]                UNIT_CLOCK_CONTROL,
	output reg  [`NUM_UNITS-1:0]      UNIT_CLOCK_ENABLE,
	output reg                        I2C2_CLOCK_ENABLE
);
	reg  [2:0]  host_sync_q;
	reg  [2:0]  pci_sync_q;
	reg         host_filt_q;
	reg         pci_filt_q;
	reg         cfg_loaded_q;
	reg         host_mode_q;
	reg         div_strap_q;
	reg  [3:0]  mult_field_q;
	reg  [6:0]  core_q;
	reg  [1:0]  vco_q;
	reg         memcm_q;
	reg         lb_mode_q;
	reg         ref_prev_q;
	reg  [11:0] unit_ctrl_q;
	reg  [11:0] unit_ctrl_d;
	reg  [3:0]  lb_half;
	reg  [3:0]  mult_raw;
	wire        ref_level;
	wire        ref_rise;
	wire        ref_half;
	wire        mem_half;
	wire        lb_clk;
	wire [5:0]  unit_en_d;

	// Pin clocks pass three stages; the filtered level moves once stages two and three agree.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			host_sync_q <= 3'h0;
			pci_sync_q  <= 3'h0;
			host_filt_q <= 1'b0;
			pci_filt_q  <= 1'b0;
		end else begin
			host_sync_q <= {host_sync_q[1:0], HOST_REF_CLOCK_IN};
			pci_sync_q  <= {pci_sync_q[1:0], PCI_CLOCK_IN};
			if (host_sync_q[1] == host_sync_q[2])
				host_filt_q <= host_sync_q[2];
			if (pci_sync_q[1] == pci_sync_q[2])
				pci_filt_q <= pci_sync_q[2];
		end
	end

	// Straps and the reset configuration word are captured once, on the first edge after release.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_loaded_q <= 1'b0;
			host_mode_q  <= 1'b0;
			div_strap_q  <= 1'b0;
			mult_field_q <= 4'h0;
			core_q       <= 7'h00;
			vco_q        <= 2'h0;
			memcm_q      <= 1'b0;
			lb_mode_q    <= 1'b0;
		end else if (!cfg_loaded_q) begin
			cfg_loaded_q <= 1'b1;
			host_mode_q  <= HOST_MODE_STRAP;
			div_strap_q  <= REF_DIVIDE_STRAP;
			mult_field_q <= SYSTEM_PLL_MULTIPLIER;
			core_q       <= CORE_MULTIPLIER_FIELD;
			vco_q        <= PLL_VCO_DIVIDER;
			memcm_q      <= MEMORY_CLOCK_MODE;
			lb_mode_q    <= LOCAL_BUS_CLOCK_MODE;
		end
	end

	assign ref_level = host_mode_q ? host_filt_q : pci_filt_q;
	assign ref_rise  = ref_level & ~ref_prev_q;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			ref_prev_q <= 1'b0;
		else
			ref_prev_q <= ref_level;
	end

	clock_divider u_ref_div (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.tick       (ref_rise),
		.half_count (`HALF_DIV2),
		.clk_out    (ref_half)
	);

	// Sync and bus clock outputs are driven only when the device makes the system clock.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRIMARY_CLOCK_OUT <= 1'b0;
			SYNC_OUT          <= 1'b0;
			BUS_CLOCK_OUTPUTS <= `OUT_CTRL_RESET;
		end else begin
			PRIMARY_CLOCK_OUT <= ref_level;
			SYNC_OUT          <= host_mode_q & (div_strap_q ? ref_half : ref_level);
			BUS_CLOCK_OUTPUTS <= BUS_CLOCK_OUTPUT_ENABLE &
				{`NUM_BUS_CLOCKS{host_mode_q & (div_strap_q ? ref_half : ref_level)}};
		end
	end

	// Multiplier and ratio decode of the captured configuration.
	always @* begin
		mult_raw = mult_field_q;
		if (mult_field_q < `MULT_FIRST_VALID)
			mult_raw = 4'h0;
	end

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SYNC_TO_BUS_RATIO    <= 8'h00;
			MULT_RESERVED        <= 1'b0;
			CORE_MULTIPLIER      <= 7'h00;
			VCO_DIVISION         <= 4'h0;
			MEMORY_CLOCK_RATIO   <= 2'h0;
			LOCAL_IF_CLOCK_RATIO <= 2'h0;
		end else begin
			SYNC_TO_BUS_RATIO    <= div_strap_q ? {3'h0, mult_raw, 1'b0} : {4'h0, mult_raw};
			MULT_RESERVED        <= cfg_loaded_q & (mult_field_q < `MULT_FIRST_VALID);
			CORE_MULTIPLIER      <= core_q;
			case (vco_q)
				`VCO_CODE_DIV4: VCO_DIVISION <= 4'h4;
				`VCO_CODE_DIV8: VCO_DIVISION <= 4'h8;
				`VCO_CODE_DIV2: VCO_DIVISION <= 4'h2;
				default:        VCO_DIVISION <= 4'h1;
			endcase
			MEMORY_CLOCK_RATIO   <= memcm_q ? 2'h2 : 2'h1;
			LOCAL_IF_CLOCK_RATIO <= lb_mode_q ? 2'h2 : 2'h1;
		end
	end

	clock_divider u_mem_div (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.tick       (1'b1),
		.half_count (`HALF_DIV2),
		.clk_out    (mem_half)
	);

	always @* begin
		case (LOCAL_BUS_DIVIDE_RATIO)
			`LB_DIV_CODE_2: lb_half = `LB_HALF_2;
			`LB_DIV_CODE_4: lb_half = `LB_HALF_4;
			default:        lb_half = `LB_HALF_8;
		endcase
	end

	clock_divider u_lb_div (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.tick       (1'b1),
		.half_count (lb_half),
		.clk_out    (lb_clk)
	);

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MEMORY_CLOCK_PAIR_P <= 1'b0;
			MEMORY_CLOCK_PAIR_N <= 1'b1;
			LOCAL_BUS_CLOCK_OUT <= 3'h0;
		end else begin
			MEMORY_CLOCK_PAIR_P <= mem_half;
			MEMORY_CLOCK_PAIR_N <= ~mem_half;
			LOCAL_BUS_CLOCK_OUT <= {3{lb_clk}};
		end
	end

	// Unit ratio register; the bus complex field refuses the divided ratios and keeps its value.
	always @* begin
		unit_ctrl_d = unit_ctrl_q;
		if (UNIT_CLOCK_WRITE) begin
			unit_ctrl_d[9:0] = UNIT_CLOCK_WRITE_DATA[9:0];
			if (UNIT_CLOCK_WRITE_DATA[11:10] == `UCM_OFF || UNIT_CLOCK_WRITE_DATA[11:10] == `UCM_FULL)
				unit_ctrl_d[11:10] = UNIT_CLOCK_WRITE_DATA[11:10];
		end
	end

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			unit_ctrl_q        <= `UNIT_CTRL_RESET;
			UNIT_CLOCK_CONTROL <= `UNIT_CTRL_RESET;
			UNIT_CLOCK_ENABLE  <= 6'h00;
			I2C2_CLOCK_ENABLE  <= 1'b0;
		end else begin
			unit_ctrl_q        <= unit_ctrl_d;
			UNIT_CLOCK_CONTROL <= unit_ctrl_d;
			UNIT_CLOCK_ENABLE  <= unit_en_d;
			I2C2_CLOCK_ENABLE  <= 1'b1;
		end
	end

	// Each unit gets a clock-enable pulse at its ratio of the system clock.
	genvar u;
	generate
		for (u = 0; u < `NUM_UNITS; u = u + 1) begin : g_unit
			reg  [1:0] phase_q;
			wire [1:0] mode = unit_ctrl_q[2*u+1:2*u];
			always @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N)
					phase_q <= 2'h0;
				else if (mode == `UCM_THIRD)
					phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
				else
					phase_q <= {1'b0, ~phase_q[0]};
			end
			// Half and third ratios pass one cycle of every two or three; off passes none.
			assign unit_en_d[u] = (mode == `UCM_FULL) ||
				((mode == `UCM_HALF || mode == `UCM_THIRD) && phase_q == 2'h0);
		end
	endgenerate
endmodule // system_clock_generation
